// File: core/bpcr_pkg.sv
// Purpose: constants for the primary command register block
// Assumes: 32-bit configuration dword, command in low half
// Notes:   status bit 24 lives in the same dword
package bpcr_pkg;
   localparam logic [7:0]  BPCR_CMD_OFFSET   = 8'h04;
   localparam int          BPCR_IO_EN_BIT    = 0;
   localparam int          BPCR_MEM_EN_BIT   = 1;
   localparam int          BPCR_MASTER_BIT   = 2;
   localparam int          BPCR_PAL_BIT      = 5;
   localparam int          BPCR_PERR_BIT     = 6;
   localparam int          BPCR_SERR_BIT     = 8;
   localparam int          BPCR_INTDIS_BIT   = 10;
   localparam int          BPCR_MDPE_BIT     = 24;
   // Writable command bits: 0,1,2,5,6,8,10
   localparam logic [15:0] BPCR_RW_MASK      = 16'h0567;
   localparam logic [15:0] BPCR_CMD_RESET    = 16'h0000;
   localparam logic [9:0]  BPCR_PAL_MASK_A   = 10'h3C6;
   localparam logic [9:0]  BPCR_PAL_MASK_B   = 10'h3C8;
   localparam logic [9:0]  BPCR_PAL_DATA     = 10'h3C9;
endpackage

// File: core/bpcr_palette_decode.sv
// Purpose: VGA palette write address match
// Assumes: combinational, same clock domain as caller
// Notes:   only the low ten address bits are compared
`timescale 1ns/100ps
module bpcr_palette_decode
   import bpcr_pkg::*;
(
   input  wire logic [31:0] addr,   // I/O address
   output logic             hit     // Palette register hit
);
   // Upper bits ignored so ISA aliases also match
   always_comb begin
      hit = (addr[9:0] == BPCR_PAL_MASK_A) ||
            (addr[9:0] == BPCR_PAL_MASK_B) ||
            (addr[9:0] == BPCR_PAL_DATA);
   end
endmodule

// File: core/bpcr_command.sv
// Purpose: primary command register and the gates it drives
// Assumes: config accesses arrive as one-cycle strobes on the core clock
// Notes:   reads return the command word plus the parity status bit
`timescale 1ns/100ps
module bpcr_command
   import bpcr_pkg::*;
(
   input  wire logic        clock,          // Core clock, 200 MHz
   input  wire logic        rst,            // Synchronous reset, active high
   input  wire logic        reverse_mode,   // High when bridge runs in reverse
   input  wire logic        cfg_wr,         // Config write strobe
   input  wire logic        cfg_rd,         // Config read strobe
   input  wire logic [7:0]  cfg_addr,       // Config dword byte offset
   input  wire logic [3:0]  cfg_be,         // Config byte enables
   input  wire logic [31:0] cfg_wdata,      // Config write data
   output logic      [31:0] cfg_rdata_q,    // Config read data
   output logic             cfg_ack_q,      // Read or write done
   input  wire logic        pri_io_req,     // Primary I/O request seen
   input  wire logic        pri_io_write,   // Primary I/O request is a write
   input  wire logic [31:0] pri_io_addr,    // Primary I/O address
   input  wire logic        pri_mem_rd_req, // Primary memory read seen
   input  wire logic        sec_req,        // Secondary mem/IO request seen
   input  wire logic        fwd_req,        // Forwarded transaction waiting
   input  wire logic        parity_event,   // Poisoned TLP or parity error
   input  wire logic        error_event,    // Bridge wants to report an error
   input  wire logic        int_req,        // Internal interrupt request
   output logic             pri_io_claim_q, // Claim primary I/O
   output logic             pri_mem_claim_q,// Claim primary memory read
   output logic             sec_claim_q,    // Claim secondary transaction
   output logic             pri_master_q,   // Start primary master cycle
   output logic             err_msg_q,      // Send error message upstream
   output logic             serr_o_q,       // SERR drive level, always low
   output logic             serr_oe_q,      // SERR output enable
   output logic             inta_o_q,       // INTA drive level, always low
   output logic             inta_oe_q,      // INTA output enable
   output logic             special_claim_q,// Always low
   output logic             mwi_orig_q,     // Always low
   output logic             mdpe_q          // Master data parity status
);
   logic [15:0] cmd_q;      // Command half of the dword
   logic [15:0] cmd_d;      // Next command value
   logic        pal_hit;    // Address is a palette register
   logic        pal_claim;  // Reverse-mode palette write snooped
   logic        hit_cmd;    // Access targets the command dword
   logic        wr_hit;     // Write to the command dword
   logic        rd_hit;     // Read of the command dword
   logic [15:0] lane_mask;  // Byte enables spread over command bits
   logic        mdpe_set;   // Parity event while reporting enabled
   logic        mdpe_clr;   // Write of one to the status bit
   logic [31:0] rd_word;    // Dword as a read returns it

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // A slipped mask would make a fixed-zero bit writable
   if (BPCR_RW_MASK != ((16'h0001 << BPCR_IO_EN_BIT)  |
                        (16'h0001 << BPCR_MEM_EN_BIT) |
                        (16'h0001 << BPCR_MASTER_BIT) |
                        (16'h0001 << BPCR_PAL_BIT)    |
                        (16'h0001 << BPCR_PERR_BIT)   |
                        (16'h0001 << BPCR_SERR_BIT)   |
                        (16'h0001 << BPCR_INTDIS_BIT))) begin : g_bad_mask
      $error("Writable mask does not match the command bit positions");
   end
   // Status clear is steered by byte enable 3 only
   if (BPCR_MDPE_BIT < 24 || BPCR_MDPE_BIT > 31) begin : g_bad_mdpe
      $error("Parity status bit outside the top byte lane");
   end
   if (BPCR_CMD_OFFSET[1:0] != 2'b00) begin : g_bad_offset
      $error("Command offset is not dword aligned");
   end
   if ((BPCR_CMD_RESET & ~BPCR_RW_MASK) != 16'h0000) begin : g_bad_reset
      $error("Reset value sets a read-only command bit");
   end

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   assign hit_cmd = (cfg_addr == BPCR_CMD_OFFSET);
   assign wr_hit  = cfg_wr && hit_cmd;
   assign rd_hit  = cfg_rd && hit_cmd;

   // One enable per byte lane of the command half
   for (genvar lane = 0; lane < 2; lane++) begin : g_lane
      assign lane_mask[8*lane +: 8] = {8{cfg_be[lane]}};
   end

   // Fixed-zero bits dropped by the mask, so writes to them vanish
   always_comb begin
      cmd_d = cmd_q;
      if (wr_hit) begin
         cmd_d = (cmd_q & ~lane_mask) | (cfg_wdata[15:0] & lane_mask & BPCR_RW_MASK);
      end
   end

   // ----------------------------------------
   // Command register
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_q <= BPCR_CMD_RESET;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // ----------------------------------------
   // Palette snoop
   // ----------------------------------------
   bpcr_palette_decode u_pal (
      .addr (pri_io_addr),
      .hit  (pal_hit)
   );

   // Writes only; palette reads stay with the graphics card
   assign pal_claim = reverse_mode && pri_io_write && cmd_q[BPCR_PAL_BIT] && pal_hit;

   // ----------------------------------------
   // Parity status, set beats clear
   // ----------------------------------------
   assign mdpe_set = parity_event && cmd_q[BPCR_PERR_BIT];
   assign mdpe_clr = wr_hit && cfg_be[3] && cfg_wdata[BPCR_MDPE_BIT];

   // A clear landing with a new event must not lose that event
   always_ff @(posedge clock) begin
      if (rst) begin
         mdpe_q <= 1'b0;
      end else if (mdpe_set) begin
         mdpe_q <= 1'b1;
      end else if (mdpe_clr) begin
         mdpe_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Config bus answer
   // ----------------------------------------
   always_comb begin
      rd_word                = {16'h0000, cmd_q};
      rd_word[BPCR_MDPE_BIT] = mdpe_q;
   end

   // Every access is answered, mapped or not
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_ack_q <= 1'b0;
      end else begin
         cfg_ack_q <= cfg_wr || cfg_rd;
      end
   end

   // Data held only for the answer cycle, zero otherwise
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_rdata_q <= 32'h0000_0000;
      end else if (rd_hit) begin
         cfg_rdata_q <= rd_word;
      end else begin
         cfg_rdata_q <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Primary target claims
   // ----------------------------------------
   // Palette snoop claims writes even with I/O space off
   always_ff @(posedge clock) begin
      if (rst) begin
         pri_io_claim_q  <= 1'b0;
         pri_mem_claim_q <= 1'b0;
      end else begin
         pri_io_claim_q  <= pri_io_req && (cmd_q[BPCR_IO_EN_BIT] || pal_claim);
         pri_mem_claim_q <= pri_mem_rd_req && cmd_q[BPCR_MEM_EN_BIT];
      end
   end

   // ----------------------------------------
   // Bus mastering
   // ----------------------------------------
   // Both directions hang on one bit, so the secondary side goes quiet too
   always_ff @(posedge clock) begin
      if (rst) begin
         sec_claim_q  <= 1'b0;
         pri_master_q <= 1'b0;
      end else begin
         sec_claim_q  <= sec_req && cmd_q[BPCR_MASTER_BIT];
         pri_master_q <= fwd_req && cmd_q[BPCR_MASTER_BIT];
      end
   end

   // ----------------------------------------
   // Unsupported features
   // ----------------------------------------
   // Kept as flops so the port stays registered like its neighbours
   always_ff @(posedge clock) begin
      if (rst) begin
         special_claim_q <= 1'b0;
         mwi_orig_q      <= 1'b0;
      end else begin
         special_claim_q <= 1'b0;
         mwi_orig_q      <= 1'b0;
      end
   end

   // ----------------------------------------
   // Error signalling
   // ----------------------------------------
   // Open-drain: drive low only while enabled
   always_ff @(posedge clock) begin
      if (rst) begin
         err_msg_q <= 1'b0;
         serr_o_q  <= 1'b0;
         serr_oe_q <= 1'b0;
      end else begin
         err_msg_q <= error_event && !reverse_mode && cmd_q[BPCR_SERR_BIT];
         serr_oe_q <= error_event && reverse_mode && cmd_q[BPCR_SERR_BIT];
         serr_o_q  <= 1'b0;
      end
   end

   // ----------------------------------------
   // Legacy interrupt
   // ----------------------------------------
   // Forward mode signals interrupts as messages elsewhere, never on this pin
   always_ff @(posedge clock) begin
      if (rst) begin
         inta_o_q  <= 1'b0;
         inta_oe_q <= 1'b0;
      end else begin
         inta_oe_q <= int_req && reverse_mode && !cmd_q[BPCR_INTDIS_BIT];
         inta_o_q  <= 1'b0;
      end
   end
endmodule

// File: verification/bpcr_command_chk.sv
// Purpose: port checks for the primary command register
// Assumes: one clock, synchronous reset
// Notes:   bound from the bench top
`timescale 1ns/100ps
module bpcr_command_chk (
   input wire logic        clock, rst, cfg_wr, cfg_rd, cfg_ack_q, reverse_mode, // Clock, reset, config
   input wire logic [31:0] cfg_rdata_q,                                         // Read data
   input wire logic        pri_mem_rd_req, pri_mem_claim_q, fwd_req, pri_master_q, // Gates
   input wire logic        error_event, serr_oe_q, parity_event, mdpe_q, special_claim_q, mwi_orig_q // Events
);
   // ----
   // Port relations
   // ----
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   cfg_ack_a: assert property (cfg_ack_q == $past(cfg_wr || cfg_rd)) else $error("ack latency wrong");
   ro_zero_a: assert property (cfg_ack_q |-> (cfg_rdata_q & 32'hFEFF_FA98) == 32'h0) else $error("ro set");
   spc_never_a: assert property (!special_claim_q) else $error("special claim");
   mwi_never_a: assert property (!mwi_orig_q) else $error("mwi originated");
   mem_cause_a: assert property (pri_mem_claim_q |-> $past(pri_mem_rd_req)) else $error("mem claim");
   mst_cause_a: assert property (pri_master_q |-> $past(fwd_req)) else $error("master start");
   serr_cause_a: assert property (serr_oe_q |-> $past(error_event) && $past(reverse_mode)) else $error("serr");
   mdpe_cause_a: assert property ($rose(mdpe_q) |-> $past(parity_event)) else $error("mdpe set");
endmodule

// File: verification/bpcr_cfg_sw.sv
// Purpose: configuration software issuing config accesses
// Assumes: one-cycle strobes launched after a rising edge
// Notes:   idle address and data lines toggle, stale values are never trusted
`timescale 1ns/100ps
module bpcr_cfg_sw (
   input  wire logic [31:0] cfg_rdata_q, // Read data
   input  wire logic        clock,       // Core clock
   output logic             cfg_wr,      // Write strobe
   output logic             cfg_rd,      // Read strobe
   output logic [7:0]       cfg_addr,    // Byte offset
   output logic [3:0]       cfg_be,      // Byte enables
   output logic [31:0]      cfg_wdata    // Write data
);
   initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                         output logic [31:0] q);
      @(posedge clock);
      {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} <= {w, !w, a, b, d};
      @(posedge clock);
      {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {2'b0, ~a, ~d};
      #1 q = cfg_rdata_q;
   endtask
endmodule

// File: verification/test_bridge_primary_command_register.sv
// Purpose: self-checking bench for the primary command register
// Assumes: inputs change by non-blocking assignment at rising edges
// Notes:   gate outputs are sampled one cycle after each request
`timescale 1ns/100ps
module test_bridge_primary_command_register;
   logic        clock = 0, rst = 1, reverse_mode = 0, pri_io_write = 0, cfg_wr, cfg_rd, cfg_ack_q, mdpe_q;
   logic [31:0] pri_io_addr = '0, q, cfg_wdata, cfg_rdata_q;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be;
   logic [6:0]  req = '0;
   logic        pri_io_req, pri_mem_rd_req, sec_req, fwd_req, error_event, int_req, parity_event;
   logic        pri_io_claim_q, pri_mem_claim_q, sec_claim_q, pri_master_q, err_msg_q, serr_o_q;
   logic        serr_oe_q, inta_o_q, inta_oe_q, special_claim_q, mwi_orig_q;
   int          fail_count = 0, total_checks = 0, cycles = 0;
   wire  [6:0]  outs = {pri_io_claim_q, pri_mem_claim_q, sec_claim_q, pri_master_q, err_msg_q, serr_oe_q, inta_oe_q};
   assign {pri_io_req, pri_mem_rd_req, sec_req, fwd_req, error_event, int_req, parity_event} = req;
   bpcr_command u_dut (.*);
   bpcr_cfg_sw  u_sw (.*);
   // ----
   // Checks and scenarios
   // ----
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic step(input logic [6:0] r, input logic [31:0] a, input logic [6:0] e);
      @(posedge clock) req <= r;
      pri_io_addr <= a;
      @(posedge clock) req <= '0;
      #1 chk("gates", {25'h0, e}, {25'h0, outs});
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      u_sw.access(1'b0, a, 4'hF, '0, q);
      chk("cfg_rdata_q", e, q);
   endtask
   task automatic t_regs;
      rdchk(8'h04, 32'h0);
      u_sw.access(1'b1, 8'h04, 4'h3, 32'hFFFF_FFFF, q);
      rdchk(8'h04, 32'h0000_0567);
      u_sw.access(1'b1, 8'h04, 4'h2, 32'h0, q);
      u_sw.access(1'b1, 8'h08, 4'hF, 32'h0, q);
      rdchk(8'h08, 32'h0);
      rdchk(8'h04, 32'h0000_0067);
   endtask
   task automatic t_gates;
      u_sw.access(1'b1, 8'h04, 4'h3, 32'h0, q);
      step(7'h7C, 32'h0, 7'h00);
      u_sw.access(1'b1, 8'h04, 4'h3, 32'h0107, q);
      step(7'h7C, 32'h0, 7'h7C);
      chk("fixed_zero", 32'h0, {30'h0, special_claim_q, mwi_orig_q});
   endtask
   task automatic t_par;
      step(7'h01, 32'h0, 7'h00);
      chk("mdpe_q", 32'h0, {31'h0, mdpe_q});
      u_sw.access(1'b1, 8'h04, 4'h3, 32'h0040, q);
      step(7'h01, 32'h0, 7'h00);
      rdchk(8'h04, 32'h0100_0040);
      u_sw.access(1'b1, 8'h04, 4'h8, 32'h0100_0000, q);
      rdchk(8'h04, 32'h0000_0040);
   endtask
   task automatic t_rev;
      logic [9:0] pal [3] = '{10'h3C6, 10'h3C8, 10'h3C9};
      @(posedge clock) reverse_mode <= 1'b1;
      pri_io_write <= 1'b1;
      u_sw.access(1'b1, 8'h04, 4'h3, 32'h0020, q);
      for (int i = 0; i < 3; i++) step(7'h40, {22'h2AF37C, pal[i]}, 7'h40);
      step(7'h40, 32'h0000_03C7, 7'h00);
      u_sw.access(1'b1, 8'h04, 4'h3, 32'h0100, q);
      step(7'h46, 32'h0000_03C6, 7'h03);
      chk("pin_levels", 32'h0, {30'h0, serr_o_q, inta_o_q});
      u_sw.access(1'b1, 8'h04, 4'h3, 32'h0400, q);
      step(7'h06, 32'h0, 7'h00);
   endtask
   task automatic report_and_stop;
      if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      t_regs;
      t_gates;
      t_par;
      t_rev;
      report_and_stop;
   end
endmodule
bind bpcr_command bpcr_command_chk u_chk (.*);
